// File: uefm_manager.v
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uefm_defs.vh"
module uefm_manager #(
   parameter [19:0] IDLE_CYCLES = `UEFM_IDLE_CYCLES
) (
   input  wire        clock_i,        // Module clock, 200 MHz
   input  wire        rst_n_i,        // Synchronous reset, active low
   input  wire        psel,           // APB select
   input  wire        penable,        // APB access phase
   input  wire        pwrite,         // APB direction
   input  wire [11:0] paddr,          // APB byte address
   input  wire [31:0] pwdata,         // APB write data
   output reg  [31:0] prdata,         // APB read data
   output reg         pready,         // APB ready
   output reg         pslverr,        // APB error on unmapped address
   input  wire        tx_rd_i,        // Engine reads one TX byte
   output reg  [7:0]  tx_byte_o,      // TX byte presented to engine
   output reg  [6:0]  tx_len_o,       // Bytes to send, from byte count
   output reg         tx_avail_o,     // Committed set may be read
   input  wire        tx_end_i,       // TX transfer ended
   input  wire        tx_fail_i,      // TX ended in error
   input  wire        tx_acked_i,     // TX acknowledged by host
   input  wire        rx_wr_i,        // Engine writes one RX byte
   input  wire [7:0]  rx_byte_i,      // RX byte from engine
   input  wire        rx_end_i,       // RX transfer ended
   input  wire        rx_fail_i,      // RX ended in error
   input  wire        rx_acked_i,     // RX acknowledged
   input  wire        setup_tok_i,    // SETUP token detected
   input  wire        bus_active_i,   // Bus activity seen, from the pins
   output reg         suspended_o,    // Device is suspended
   output reg         wake_enable_o   // Remote wake-up allowed
);
   localparam [1:0] TX_IDLE  = 2'b01;
   localparam [1:0] TX_READY = 2'b10;

   reg  [1:0]  tx_state;
   reg  [3:0]  tx_wptr;
   reg  [2:0]  tx_rptr;
   reg  [6:0]  tx_byte_count;
   reg         tx_buffer_vacant;
   reg  [3:0]  rx_wptr;
   reg  [2:0]  rx_rptr;
   reg  [6:0]  rx_byte_count;
   reg         rx_set_ready;
   reg         rx_buffer_vacant;
   reg         rx_fail;
   reg         rx_acked;
   reg         ovw_start;
   reg         ovw_end;
   reg  [1:0]  size_sel;
   reg  [7:0]  second_bank_select;
   reg  [4:0]  bank_index;
   reg  [8:0]  iso_in_base_offset;
   reg  [19:0] idle_cnt;
   wire        bus_active_s;
   wire [7:0]  tx_mem_q;
   wire [7:0]  rx_mem_q;
   wire        tx_set_ready = tx_state[1];
   wire        acc     = psel & penable & pready;
   wire        wr_acc  = acc & pwrite;
   wire        rd_acc  = acc & ~pwrite;
   wire        tx_data_port_wr = wr_acc & (paddr == `UEFM_TX_DATA_ADDR) & ~tx_set_ready;
   wire        tx_cnt_wr = wr_acc & (paddr == `UEFM_TX_COUNT_ADDR) & ~tx_set_ready;
   wire        tx_store  = tx_data_port_wr & ~tx_wptr[3];
   wire        tx_take   = tx_rd_i & tx_avail_o & (tx_wptr != 4'h0);
   wire        rx_lock   = ovw_start | ovw_end;
   wire        rx_cpu_rd = rd_acc & (paddr == `UEFM_RX_DATA_ADDR) & rx_set_ready
                           & ~rx_buffer_vacant & ~rx_lock & (rx_wptr != 4'h0);
   // SETUP data must still land while start-overwrite locks the read side
   wire        rx_store  = rx_wr_i & ~rx_set_ready & ~rx_wptr[3];
   wire        rd_done   = wr_acc & (paddr == `UEFM_RX_CONTROL_ADDR)
                           & pwdata[`UEFM_CTRL_RDDONE_BIT] & ~rx_lock;
   wire [10:0] bank_start = {1'b0, bank_index, 5'h00} << 1;
   wire [10:0] iso_first  = `UEFM_ISO_FIRST + {2'b00, iso_in_base_offset};
   wire [10:0] iso_second = `UEFM_ISO_SECOND + {2'b00, iso_in_base_offset};
   wire [6:0]  size_limit = 7'h08 << size_sel;

   // Shared memory is only eight bytes per direction; the set size just caps the count
   uefm_buffer u_tx_mem (
      .clock_i   (clock_i),
      .wr_en_i   (tx_store),
      .wr_addr_i (tx_wptr[2:0] + tx_rptr),
      .wr_data_i (pwdata[7:0]),
      .rd_addr_i (tx_rptr),
      .rd_data_o (tx_mem_q)
   );
   uefm_buffer u_rx_mem (
      .clock_i   (clock_i),
      .wr_en_i   (rx_store),
      .wr_addr_i (rx_wptr[2:0]),
      .wr_data_i (rx_byte_i),
      .rd_addr_i (rx_rptr),
      .rd_data_o (rx_mem_q)
   );
   uefm_sync u_act_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .async_i (bus_active_i),
      .sync_o  (bus_active_s)
   );

   // Transmit side
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         tx_state         <= TX_IDLE;
         tx_buffer_vacant <= `UEFM_VACANT_RST;
         tx_wptr          <= 4'h0;
         tx_rptr          <= 3'h0;
         tx_byte_count    <= 7'h00;
         tx_avail_o       <= 1'b0;
         tx_len_o         <= 7'h00;
         tx_byte_o        <= 8'h00;
      end else begin
         if (tx_store) begin
            tx_wptr          <= tx_wptr + 4'h1;
            tx_buffer_vacant <= 1'b0;
         end
         if (tx_take) begin
            tx_wptr   <= tx_wptr - 4'h1;
            tx_rptr   <= tx_rptr + 3'h1;
            tx_byte_o <= tx_mem_q;
         end
         case (tx_state)
            TX_IDLE: begin
               if (tx_cnt_wr) begin
                  tx_state      <= TX_READY;
                  tx_byte_count <= (pwdata[6:0] > size_limit) ? size_limit : pwdata[6:0];
                  tx_len_o      <= (pwdata[6:0] > size_limit) ? size_limit : pwdata[6:0];
                  tx_avail_o    <= 1'b1;
               end
            end
            TX_READY: begin
               if (tx_end_i && tx_acked_i && !tx_fail_i) begin
                  tx_state         <= TX_IDLE;
                  tx_buffer_vacant <= 1'b1;
                  tx_avail_o       <= 1'b0;
                  tx_wptr          <= 4'h0;
                  tx_rptr          <= 3'h0;
               end else if (tx_end_i && tx_fail_i) begin
                  // Rewound bytes count as unread again for the retry
                  tx_wptr <= tx_wptr + {1'b0, tx_rptr};
                  tx_rptr <= 3'h0;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // Receive side
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         rx_set_ready     <= `UEFM_READY_RST;
         rx_buffer_vacant <= `UEFM_VACANT_RST;
         rx_wptr          <= 4'h0;
         rx_rptr          <= 3'h0;
         rx_byte_count    <= 7'h00;
         rx_fail          <= 1'b0;
         rx_acked         <= 1'b0;
         ovw_start        <= 1'b0;
         ovw_end          <= 1'b0;
      end else begin
         if (setup_tok_i) begin
            // Flush wins over a CPU read landing in the same cycle
            rx_set_ready     <= 1'b0;
            rx_buffer_vacant <= 1'b1;
            rx_wptr          <= 4'h0;
            rx_rptr          <= 3'h0;
            rx_byte_count    <= 7'h00;
            ovw_start        <= 1'b1;
         end else begin
            if (rx_store) begin
               rx_wptr          <= rx_wptr + 4'h1;
               rx_buffer_vacant <= 1'b0;
            end
            if (rx_wr_i && !rx_set_ready && rx_byte_count < size_limit) begin
               rx_byte_count <= rx_byte_count + 7'h01;
            end
            if (rx_cpu_rd) begin
               rx_wptr <= rx_wptr - 4'h1;
               rx_rptr <= rx_rptr + 3'h1;
            end
            if (rx_end_i) begin
               rx_acked <= rx_acked_i & ~rx_fail_i;
               rx_fail  <= rx_fail_i;
               if (rx_acked_i && !rx_fail_i && !rx_set_ready) begin
                  rx_set_ready <= 1'b1;
                  if (ovw_start) begin
                     ovw_start <= 1'b0;
                     ovw_end   <= 1'b1;
                  end
               end else if (rx_fail_i && !rx_set_ready) begin
                  rx_wptr          <= 4'h0;
                  rx_byte_count    <= 7'h00;
                  rx_buffer_vacant <= 1'b1;
               end
            end else if (rd_done) begin
               rx_set_ready     <= 1'b0;
               rx_buffer_vacant <= 1'b1;
               rx_wptr          <= 4'h0;
               rx_rptr          <= 3'h0;
               rx_byte_count    <= 7'h00;
            end
            // Software clears end-overwrite by writing one; the hardware set wins
            if (wr_acc && paddr == `UEFM_RX_STATUS_ADDR && pwdata[`UEFM_STAT_EDOVW_BIT]
                && !(rx_end_i && rx_acked_i && ovw_start)) begin
               ovw_end <= 1'b0;
            end
         end
      end
   end

   // Configuration, suspend and APB answer
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         size_sel           <= `UEFM_SIZE_RST;
         wake_enable_o      <= 1'b0;
         second_bank_select <= 8'h00;
         bank_index         <= 5'h00;
         iso_in_base_offset <= 9'h000;
         idle_cnt           <= 20'h00000;
         suspended_o        <= 1'b0;
         prdata             <= 32'h00000000;
         pready             <= 1'b0;
         pslverr            <= 1'b0;
      end else begin
         if (bus_active_s) begin
            idle_cnt    <= 20'h00000;
            suspended_o <= 1'b0;
         end else if (idle_cnt >= IDLE_CYCLES - 20'h00001) begin
            suspended_o <= 1'b1;
         end else begin
            idle_cnt <= idle_cnt + 20'h00001;
         end
         if (wr_acc) begin
            case (paddr)
               `UEFM_CONFIG_ADDR: begin
                  size_sel      <= pwdata[1:0];
                  wake_enable_o <= pwdata[`UEFM_CFG_WAKE_BIT];
               end
               `UEFM_DBCON_ADDR: second_bank_select <= pwdata[7:0];
               `UEFM_BANK_ADDR: begin
                  bank_index         <= pwdata[4:0];
                  iso_in_base_offset <= pwdata[24:16];
               end
               default: ;
            endcase
         end
         // No wait state: setup, then access with pready high
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel && !penable) begin
            case (paddr)
               `UEFM_TX_DATA_ADDR, `UEFM_TX_COUNT_ADDR: prdata <= {25'h0, tx_byte_count};
               `UEFM_TX_FLAG_ADDR:
                  prdata <= {30'h0, tx_set_ready, tx_buffer_vacant};
               `UEFM_RX_DATA_ADDR:
                  prdata <= (rx_set_ready && !rx_lock && rx_wptr != 4'h0) ?
                            {24'h0, rx_mem_q} : 32'h0;
               `UEFM_RX_COUNT_ADDR: prdata <= {25'h0, rx_byte_count};
               `UEFM_RX_FLAG_ADDR:
                  prdata <= {30'h0, rx_set_ready, rx_buffer_vacant};
               `UEFM_RX_CONTROL_ADDR: prdata <= 32'h0;
               `UEFM_RX_STATUS_ADDR:
                  prdata <= {26'h0, ovw_start, ovw_end, 2'b00, rx_fail, rx_acked};
               `UEFM_CONFIG_ADDR:
                  prdata <= {29'h0, wake_enable_o, size_sel};
               `UEFM_SUSPEND_ADDR: prdata <= {31'h0, suspended_o};
               `UEFM_DBCON_ADDR: prdata <= {24'h0, second_bank_select};
               `UEFM_BANK_ADDR:
                  prdata <= {5'h0, iso_first, 5'h0, bank_start};
               default: begin
                  prdata  <= 32'h0;
                  pslverr <= 1'b1;
               end
            endcase
            // Banks 16 and up lie in the second-buffer region
            if (paddr == `UEFM_BANK_ADDR && pwrite == 1'b0 && bank_index[4]) begin
               prdata <= {5'h0, iso_second, 5'h0, bank_start};
            end
         end
      end
   end
endmodule // uefm_manager
`default_nettype wire

// File: uefm_defs.vh
`ifndef UEFM_DEFS_VH
`define UEFM_DEFS_VH
// Register byte addresses
`define UEFM_TX_DATA_ADDR    12'h000
`define UEFM_TX_COUNT_ADDR   12'h004
`define UEFM_TX_FLAG_ADDR    12'h008
`define UEFM_RX_DATA_ADDR    12'h00C
`define UEFM_RX_COUNT_ADDR   12'h010
`define UEFM_RX_FLAG_ADDR    12'h014
`define UEFM_RX_CONTROL_ADDR 12'h018
`define UEFM_RX_STATUS_ADDR  12'h01C
`define UEFM_CONFIG_ADDR     12'h020
`define UEFM_SUSPEND_ADDR    12'h024
`define UEFM_DBCON_ADDR      12'h028
`define UEFM_BANK_ADDR       12'h02C
// Flag register fields
`define UEFM_FLAG_READY_BIT  1
`define UEFM_FLAG_VACANT_BIT 0
// Receive status fields
`define UEFM_STAT_STOVW_BIT  5
`define UEFM_STAT_EDOVW_BIT  4
`define UEFM_STAT_ERR_BIT    1
`define UEFM_STAT_ACK_BIT    0
// Control fields
`define UEFM_CTRL_RDDONE_BIT 0
`define UEFM_CFG_SIZE_LSB    0
`define UEFM_CFG_WAKE_BIT    2
// Reset values
`define UEFM_READY_RST       1'b0
`define UEFM_VACANT_RST      1'b1
`define UEFM_SIZE_RST        2'h0
// Buffer geometry
`define UEFM_BUF_STORE       8
`define UEFM_BANK_SHIFT      6
`define UEFM_ISO_FIRST       11'h200
`define UEFM_ISO_SECOND      11'h400
// Suspend idle time
`define UEFM_IDLE_US         3000
`define UEFM_CLK_MHZ         200
`define UEFM_IDLE_CYCLES     (`UEFM_IDLE_US * `UEFM_CLK_MHZ)
`endif

// File: uefm_sync.v
`timescale 1ns/1ps
`default_nettype none
module uefm_sync (
   input  wire clock_i,  // Module clock
   input  wire rst_n_i,  // Synchronous reset, active low
   input  wire async_i,  // Level from outside the domain
   output reg  sync_o    // Synchronised level
);
   reg meta;
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         meta   <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule // uefm_sync
`default_nettype wire

// File: uefm_buffer.v
`timescale 1ns/1ps
`default_nettype none
`include "uefm_defs.vh"
module uefm_buffer (
   input  wire       clock_i,   // Module clock
   input  wire       wr_en_i,   // Store a byte
   input  wire [2:0] wr_addr_i, // Store slot
   input  wire [7:0] wr_data_i, // Byte to store
   input  wire [2:0] rd_addr_i, // Read slot
   output wire [7:0] rd_data_o  // Byte at read slot
);
   reg [7:0] mem [0:`UEFM_BUF_STORE-1];
   always @(posedge clock_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end
   assign rd_data_o = mem[rd_addr_i];
endmodule // uefm_buffer
`default_nettype wire

// File: uefm_manager_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "uefm_defs.vh"
module uefm_manager_asserts #(
   parameter [19:0] IDLE_CYCLES = `UEFM_IDLE_CYCLES
) (
   input wire logic        clock_i, rst_n_i, psel, penable, pwrite, pready, pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic        tx_rd_i, tx_avail_o, tx_end_i, tx_fail_i, tx_acked_i,
   input wire logic [7:0]  tx_byte_o, rx_byte_i,
   input wire logic [6:0]  tx_len_o,
   input wire logic        rx_wr_i, rx_end_i, rx_fail_i, rx_acked_i, setup_tok_i,
   input wire logic        bus_active_i, suspended_o, wake_enable_o
);
   logic [31:0] idle_cnt;
   wire         wr_done = psel && penable && pwrite && pready;
   wire         cnt_wr = wr_done && (paddr == `UEFM_TX_COUNT_ADDR);
   wire         cfg_wr = wr_done && (paddr == `UEFM_CONFIG_ADDR);
   // Counts raw idle cycles; the design counts after its synchroniser, so it lags
   always @(posedge clock_i) begin
      if (!rst_n_i || bus_active_i) begin
         idle_cnt <= 32'h0;
      end else begin
         idle_cnt <= idle_cnt + 32'h1;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   a_apb_answer: assert property (psel && !penable ##1 psel && penable |-> pready)
      else $error("pready missing in access phase");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held beyond one cycle");
   a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("pslverr outside an access");
   a_reset_state: assert property ($rose(rst_n_i) |-> !tx_avail_o && !suspended_o)
      else $error("outputs not idle after reset");
   a_avail_cause: assert property ($rose(tx_avail_o) |->
      $past(cnt_wr) || $past(cnt_wr, 2) || $past(tx_fail_i) || $past(tx_fail_i, 2))
      else $error("transmit set committed without a count write");
   a_ack_clears: assert property (tx_end_i && tx_acked_i |-> ##[1:2] !tx_avail_o)
      else $error("acknowledged set still offered");
   a_len_limit: assert property (tx_len_o <= 7'h40)
      else $error("transmit length above 64");
   a_suspend_idle: assert property ($rose(suspended_o) |-> idle_cnt >= IDLE_CYCLES)
      else $error("suspend entered too early");
   a_suspend_exit: assert property (bus_active_i [*6] |=> !suspended_o)
      else $error("suspend held during bus activity");
   a_wake_cfg: assert property (cfg_wr |-> ##2 wake_enable_o == $past(pwdata[2], 2))
      else $error("wake enable does not follow config");
   c_count_wr: cover property (cnt_wr);
   c_suspend: cover property ($rose(suspended_o));
   c_setup: cover property (setup_tok_i);
   c_slverr: cover property (pslverr);
endmodule // uefm_manager_asserts
bind uefm_manager uefm_manager_asserts #(.IDLE_CYCLES(IDLE_CYCLES)) i_chk (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .tx_rd_i(tx_rd_i), .tx_avail_o(tx_avail_o), .tx_end_i(tx_end_i), .tx_fail_i(tx_fail_i),
   .tx_acked_i(tx_acked_i), .tx_byte_o(tx_byte_o), .rx_byte_i(rx_byte_i),
   .tx_len_o(tx_len_o), .rx_wr_i(rx_wr_i), .rx_end_i(rx_end_i), .rx_fail_i(rx_fail_i),
   .rx_acked_i(rx_acked_i), .setup_tok_i(setup_tok_i), .bus_active_i(bus_active_i),
   .suspended_o(suspended_o), .wake_enable_o(wake_enable_o));
`default_nettype wire

// File: uefm_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module uefm_engine_model (
   input  wire logic       clock_i,    // Module clock
   input  wire logic       tx_avail_o, // Committed set readable
   input  wire logic [7:0] tx_byte_o,  // Byte taken
   output var logic        tx_rd_i, tx_end_i, tx_fail_i, tx_acked_i, // Transmit side
   output var logic        rx_wr_i, rx_end_i, rx_fail_i, rx_acked_i, // Receive side
   output var logic        setup_tok_i, bus_active_i, // Token and bus activity
   output var logic [7:0]  rx_byte_i   // Received byte
);
   logic [7:0] got[$];
   initial begin
      {tx_rd_i, tx_end_i, tx_fail_i, tx_acked_i, rx_wr_i, rx_end_i, rx_fail_i} = 7'h00;
      // Bus starts active and no SETUP token is pending
      {rx_acked_i, setup_tok_i, bus_active_i, rx_byte_i} = 11'h100;
   end
   task tx_take(input int n, input int gap);
      int k;
      k = 0;
      // Waits up to 50 cycles for a committed set, then reads n bytes regardless
      while (tx_avail_o !== 1'b1 && k < 50) begin
         @(posedge clock_i);
         k++;
      end
      repeat (n) begin
         repeat (gap) @(posedge clock_i);
         @(posedge clock_i);
         tx_rd_i <= 1'b1;
         @(posedge clock_i);
         tx_rd_i <= 1'b0;
         @(posedge clock_i);
         got.push_back(tx_byte_o);
      end
   endtask
   task finish(input logic tx, input logic fail, input logic ack);
      @(posedge clock_i);
      // Error and acknowledge are never reported together
      {tx_end_i, tx_fail_i, tx_acked_i} <= tx ? {1'b1, fail, ack & ~fail} : 3'h0;
      {rx_end_i, rx_fail_i, rx_acked_i} <= tx ? 3'h0 : {1'b1, fail, ack & ~fail};
      @(posedge clock_i);
      {tx_end_i, tx_fail_i, tx_acked_i, rx_end_i, rx_fail_i, rx_acked_i} <= 6'h00;
   endtask
   task rx_put(input logic [7:0] first, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clock_i);
         rx_wr_i <= 1'b1;
         rx_byte_i <= first + 8'(i);
         @(posedge clock_i);
         rx_wr_i <= 1'b0;
         // A released data line must not keep showing the last byte
         rx_byte_i <= ~(first + 8'(i));
      end
   endtask
   task setup_token();
      @(posedge clock_i);
      setup_tok_i <= 1'b1;
      @(posedge clock_i);
      setup_tok_i <= 1'b0;
   endtask
   task set_bus(input logic a);
      @(posedge clock_i);
      bus_active_i <= a;
   endtask
endmodule // uefm_engine_model
`default_nettype wire

// File: test_usb_endpoint_fifo_manager.sv
`timescale 1ns/1ps
`default_nettype none
`include "uefm_defs.vh"
module test_usb_endpoint_fifo_manager;
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] q;
   logic        err;
   int          mismatches = 0;
   int          tests_run = 0;
   wire  [31:0] prdata;
   wire  [7:0]  tx_byte_o, rx_byte_i;
   wire  [6:0]  tx_len_o;
   wire         pready, pslverr, tx_rd_i, tx_avail_o, tx_end_i, tx_fail_i, tx_acked_i, rx_wr_i;
   wire         rx_end_i, rx_fail_i, rx_acked_i, setup_tok_i, bus_active_i, suspended_o;
   wire         wake_enable_o;
   always #2.5 clock_i = ~clock_i;
   uefm_manager #(.IDLE_CYCLES(20'h00032)) i_dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_rd_i(tx_rd_i), .tx_byte_o(tx_byte_o), .tx_len_o(tx_len_o), .tx_avail_o(tx_avail_o),
      .tx_end_i(tx_end_i), .tx_fail_i(tx_fail_i), .tx_acked_i(tx_acked_i), .rx_wr_i(rx_wr_i),
      .rx_byte_i(rx_byte_i), .rx_end_i(rx_end_i), .rx_fail_i(rx_fail_i),
      .rx_acked_i(rx_acked_i), .setup_tok_i(setup_tok_i), .bus_active_i(bus_active_i),
      .suspended_o(suspended_o), .wake_enable_o(wake_enable_o));
   uefm_engine_model i_eng (
      .clock_i(clock_i), .tx_avail_o(tx_avail_o), .tx_byte_o(tx_byte_o), .tx_rd_i(tx_rd_i),
      .tx_end_i(tx_end_i), .tx_fail_i(tx_fail_i), .tx_acked_i(tx_acked_i), .rx_wr_i(rx_wr_i),
      .rx_end_i(rx_end_i), .rx_fail_i(rx_fail_i), .rx_acked_i(rx_acked_i),
      .setup_tok_i(setup_tok_i), .bus_active_i(bus_active_i), .rx_byte_i(rx_byte_i));
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) check("pready", 32'h0, 32'h1);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
      apb(1'b0, a, 32'h0);
      check(s, q & m, e);
   endtask
   task stop_test();
      $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock_i);
      mismatches++;
      stop_test();
   end
   initial begin
      int n;
      repeat (20) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd(`UEFM_TX_FLAG_ADDR, 32'h3, 32'h1, "tx flags");
      rd(`UEFM_RX_FLAG_ADDR, 32'h3, 32'h1, "rx flags");
      rd(`UEFM_RX_DATA_ADDR, 32'hFF, 32'h0, "rx empty read");
      rd(12'h0FC, 32'h0, 32'h0, "unmapped");
      check("slverr", {31'h0, err}, 32'h1);
      $display("test reset done");
      for (int i = 0; i < 3; i++) wr(`UEFM_TX_DATA_ADDR, 32'hA0 + i);
      check("avail early", {31'h0, tx_avail_o}, 32'h0);
      wr(`UEFM_TX_COUNT_ADDR, 32'h3);
      wr(`UEFM_TX_DATA_ADDR, 32'hEE);
      wr(`UEFM_TX_COUNT_ADDR, 32'h5);
      rd(`UEFM_TX_FLAG_ADDR, 32'h3, 32'h2, "tx flags set");
      check("tx len", {25'h0, tx_len_o}, 32'h3);
      // First pass fails and the same set is sent again, more slowly
      for (int r = 0; r < 2; r++) begin
         i_eng.got.delete();
         i_eng.tx_take(3, 3 * r);
         for (int i = 0; i < 3; i++) check("tx byte", {24'h0, i_eng.got[i]}, 32'hA0 + i);
         i_eng.finish(1'b1, r == 0, r == 1);
      end
      rd(`UEFM_TX_FLAG_ADDR, 32'h3, 32'h1, "tx flags acked");
      for (int s = 0; s < 4; s++) begin
         wr(`UEFM_CONFIG_ADDR, s);
         wr(`UEFM_TX_COUNT_ADDR, 32'h40);
         repeat (2) @(posedge clock_i);
         check("tx len cap", {25'h0, tx_len_o}, 32'h8 << s);
         i_eng.finish(1'b1, 1'b0, 1'b1);
      end
      wr(`UEFM_TX_COUNT_ADDR, 32'h0);
      rd(`UEFM_TX_FLAG_ADDR, 32'h3, 32'h3, "tx zero length");
      i_eng.finish(1'b1, 1'b0, 1'b1);
      $display("test transmit done");
      i_eng.rx_put(8'h10, 3);
      rd(`UEFM_RX_FLAG_ADDR, 32'h3, 32'h0, "rx arriving");
      i_eng.finish(1'b0, 1'b0, 1'b1);
      rd(`UEFM_RX_FLAG_ADDR, 32'h3, 32'h2, "rx stored");
      i_eng.rx_put(8'h50, 2);
      rd(`UEFM_RX_COUNT_ADDR, 32'h7F, 32'h3, "rx count");
      for (int i = 0; i < 3; i++) rd(`UEFM_RX_DATA_ADDR, 32'hFF, 32'h10 + i, "rx byte");
      wr(`UEFM_RX_CONTROL_ADDR, 32'h1);
      rd(`UEFM_RX_FLAG_ADDR, 32'h3, 32'h1, "rx released");
      i_eng.rx_put(8'h30, 2);
      i_eng.finish(1'b0, 1'b0, 1'b0);
      rd(`UEFM_RX_COUNT_ADDR, 32'h7F, 32'h2, "rx no status");
      i_eng.finish(1'b0, 1'b1, 1'b0);
      rd(`UEFM_RX_COUNT_ADDR, 32'h7F, 32'h0, "rx rewound");
      i_eng.finish(1'b0, 1'b0, 1'b1);
      rd(`UEFM_RX_FLAG_ADDR, 32'h3, 32'h3, "rx zero length");
      wr(`UEFM_RX_CONTROL_ADDR, 32'h1);
      $display("test receive done");
      i_eng.rx_put(8'h60, 2);
      i_eng.finish(1'b0, 1'b0, 1'b1);
      rd(`UEFM_RX_DATA_ADDR, 32'hFF, 32'h60, "rx before setup");
      i_eng.setup_token();
      rd(`UEFM_RX_STATUS_ADDR, 32'h30, 32'h20, "start overwrite");
      i_eng.rx_put(8'hC0, 8);
      i_eng.finish(1'b0, 1'b0, 1'b1);
      rd(`UEFM_RX_STATUS_ADDR, 32'h33, 32'h11, "end overwrite");
      wr(`UEFM_RX_CONTROL_ADDR, 32'h1);
      rd(`UEFM_RX_FLAG_ADDR, 32'h3, 32'h2, "locked release");
      wr(`UEFM_RX_STATUS_ADDR, 32'h10);
      for (int i = 0; i < 8; i++) rd(`UEFM_RX_DATA_ADDR, 32'hFF, 32'hC0 + i, "setup byte");
      rd(`UEFM_RX_DATA_ADDR, 32'hFF, 32'h0, "rx drained");
      wr(`UEFM_RX_CONTROL_ADDR, 32'h1);
      rd(`UEFM_RX_FLAG_ADDR, 32'h3, 32'h1, "setup released");
      $display("test setup done");
      wr(`UEFM_CONFIG_ADDR, 32'h4);
      repeat (2) @(posedge clock_i);
      check("wake enable", {31'h0, wake_enable_o}, 32'h1);
      i_eng.set_bus(1'b0);
      n = 0;
      while (suspended_o !== 1'b1 && n < 200) begin
         @(posedge clock_i);
         n++;
      end
      check("suspended", {31'h0, suspended_o}, 32'h1);
      check("idle span", {31'h0, n >= 50}, 32'h1);
      i_eng.set_bus(1'b1);
      repeat (8) @(posedge clock_i);
      check("resumed", {31'h0, suspended_o}, 32'h0);
      $display("test suspend done");
      wr(`UEFM_BANK_ADDR, 32'h0010_0005);
      rd(`UEFM_BANK_ADDR, 32'h07FF_07FF, 32'h0210_0140, "bank map");
      wr(`UEFM_BANK_ADDR, 32'h0010_0011);
      rd(`UEFM_BANK_ADDR, 32'h07FF_07FF, 32'h0410_0440, "bank map second");
      $display("test banks done");
      stop_test();
   end
endmodule // test_usb_endpoint_fifo_manager
`default_nettype wire
